// *** logic/gcsw_core.sv ***
/*
 * control and status word block of the gateway: holds the command word,
 * runs the toggle handshake, executes node commands, builds the status word.
 * assumes the fieldbus side writes bytes of the output area on sys_clk and
 * that subnetwork events arrive as one-cycle pulses on sys_clk.
 */
`timescale 1ns/1ps
// Notes on behaviour
// - generic: invalid transaction counter grew reports 0x00
// - generic: delimiter timeout before end char reports 0x01
// - generic: offline timeout counter grew reports 0x02
// - generic: overrun or early message reports 0x03
// - undefined error 0x04; errors later cleared 0x1f
// - command word at output bytes 0x200-0x201
// - bit 13 set allows subnetwork exchange
// - valid bit honoured only when fully enabled
// - bit 12 executes the coded command
// - bits 11-8 command code, 7-0 argument
// - word stored most significant byte first
// - master: code 0x00 disables given node
// - master: code 0x01 re-enables given node
// - master: code 0x02 enables first N only
// - generic mode: commands have no effect
// - mailbox: 16 header words, up to 128 data
// - parameter channel defaults to one word
// - status word at input 0x000-0x001 fields
// - fully enabled: wait for valid before exchange
module gcsw_core (
    input  wire logic                   sys_clk,
    input  wire logic                   resetn,
    // byte port into the output area
    input  wire logic                   out_wr,           // one byte write
    input  wire logic [9:0]             out_addr,
    input  wire logic [7:0]             out_wdata,
    // byte port out of the input area
    input  wire logic [9:0]             in_addr,
    output logic [7:0]                  in_rdata,
    // configuration
    input  wire gcsw_pkg::gcsw_feat_type feature,
    input  wire gcsw_pkg::gcsw_mode_type mode,
    input  wire logic                   fieldbus_online,
    input  wire logic                   param_chan_set,   // override present
    input  wire logic [7:0]             param_chan_cfg,
    // subnetwork events, one-cycle pulses
    input  wire logic                   ev_invalid_trans,
    input  wire logic                   ev_frame_timeout,
    input  wire logic                   ev_offline_timeout,
    input  wire logic                   ev_overrun,
    input  wire logic                   ev_other_err,
    input  wire logic                   all_trans_ok,     // level
    input  wire logic [7:0]             cfg_node_index,   // node queried
    // results
    output logic                        exchange_enable,
    output logic                        node_enabled,     // flag of cfg_node_index
    output logic [7:0]                  param_chan_words,
    output logic [15:0]                 status_word
);
    // =====================================================================
    // state and storage
    // =====================================================================
    localparam int        node_count_w = gcsw_pkg::node_count;
    logic [15:0]          cmd_word;                  // command word, msb first
    logic                 gw_send;                   // our send toggle
    logic                 gw_ack;                    // our ack toggle
    logic [4:0]           stat_code;
    logic [7:0]           stat_data;
    logic                 err_active;                // an error awaits 0x1f
    logic                 sub_valid;                 // all transactions done once
    logic [node_count_w-1:0] node_on;                // per-node enable
    logic                 node_on_init;              // flags loaded after reset
    logic                 frame_pend;
    logic                 overrun_pend;
    logic                 other_pend;
    // =====================================================================
    // decode of the command word fields
    // =====================================================================
    wire        host_ack_toggle  = cmd_word[gcsw_pkg::cmd_ack_bit];
    wire        host_send_toggle = cmd_word[gcsw_pkg::cmd_send_bit];
    wire        host_valid       = cmd_word[gcsw_pkg::cmd_valid_bit];
    wire        host_exec        = cmd_word[gcsw_pkg::cmd_exec_bit];
    wire [3:0]  host_code        = cmd_word[gcsw_pkg::cmd_code_hi:gcsw_pkg::cmd_code_lo];
    wire [7:0]  host_arg         = cmd_word[7:0];
    wire        is_master        = (mode != gcsw_pkg::gcsw_mode_generic);
    wire        wr_hi            = out_wr && (out_addr == gcsw_pkg::cmd_word_addr);
    wire        wr_lo            = out_wr && (out_addr == gcsw_pkg::cmd_word_addr_lo);
    // a new command arrives when the host send toggle differs from our ack
    wire        new_word         = (host_send_toggle != gw_ack);
    wire        run_cmd          = new_word && host_exec && is_master;
    // our report may go out only once the host has confirmed the last one
    wire        can_report       = (host_ack_toggle == gw_send);
    // =====================================================================
    // event counters, generic mode
    // =====================================================================
    logic       inv_pend;
    logic       off_pend;
    logic [7:0] inv_count;
    logic [7:0] off_count;
    wire        take_inv;
    wire        take_off;
    gcsw_event_count u_inv_count (
        .sys_clk     (sys_clk),
        .resetn      (resetn),
        .event_pulse (ev_invalid_trans),
        .take        (take_inv),
        .pending     (inv_pend),
        .count       (inv_count)
    );
    gcsw_event_count u_off_count (
        .sys_clk     (sys_clk),
        .resetn      (resetn),
        .event_pulse (ev_offline_timeout),
        .take        (take_off),
        .pending     (off_pend),
        .count       (off_count)
    );
    // =====================================================================
    // report selection: errors first, then warnings, then all clear
    // =====================================================================
    wire        generic    = !is_master;
    wire        sel_inv    = generic && inv_pend;
    wire        sel_off    = generic && !sel_inv && off_pend;
    wire        sel_other  = !sel_inv && !sel_off && other_pend;
    wire        sel_frame  = generic && !sel_inv && !sel_off && !sel_other
                             && frame_pend;
    wire        sel_ovr    = generic && !sel_inv && !sel_off && !sel_other
                             && !sel_frame && overrun_pend;
    wire        any_sel    = sel_inv | sel_off | sel_other | sel_frame | sel_ovr;
    // errors that lapse are closed by a no-error report
    wire        sel_clear  = !any_sel && err_active;
    wire        do_report  = can_report && (any_sel || sel_clear);
    assign take_inv = do_report && sel_inv;
    assign take_off = do_report && sel_off;
    wire [4:0]  next_code  = sel_inv   ? gcsw_pkg::code_invalid_cnt :
                             sel_off   ? gcsw_pkg::code_offline_cnt :
                             sel_other ? gcsw_pkg::code_other_err :
                             sel_frame ? gcsw_pkg::code_frame_err :
                             sel_ovr   ? gcsw_pkg::code_overrun :
                                         gcsw_pkg::code_no_error;
    wire [7:0]  next_data  = sel_inv ? inv_count :
                             sel_off ? off_count : 8'h00;
    wire        next_err   = sel_inv | sel_off | sel_other;
    // =====================================================================
    // command word storage, byte wise, msb at the lower address
    // =====================================================================
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            cmd_word <= gcsw_pkg::cmd_word_reset;
        else
        begin
            if (wr_hi)
                cmd_word[15:8] <= out_wdata;
            if (wr_lo)
                cmd_word[7:0]  <= out_wdata;
        end
    end
    // =====================================================================
    // handshake toggles and the status report
    // =====================================================================
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            gw_ack     <= 1'b0;
            gw_send    <= 1'b0;
            stat_code  <= gcsw_pkg::code_no_error;
            stat_data  <= 8'h00;
            err_active <= 1'b0;
        end
        else
        begin
            if (new_word)
                gw_ack <= host_send_toggle;
            if (do_report)
            begin
                stat_code  <= next_code;
                stat_data  <= next_data;
                err_active <= next_err;
                gw_send    <= ~gw_send;
            end
        end
    end
    // =====================================================================
    // sticky warning and other-error flags; a new event beats the take
    // =====================================================================
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            frame_pend   <= 1'b0;
            overrun_pend <= 1'b0;
            other_pend   <= 1'b0;
        end
        else
        begin
            frame_pend   <= ev_frame_timeout | (frame_pend & ~(do_report & sel_frame));
            overrun_pend <= ev_overrun | (overrun_pend & ~(do_report & sel_ovr));
            other_pend   <= ev_other_err | (other_pend & ~(do_report & sel_other));
        end
    end
    // =====================================================================
    // node enable flags, master modes only
    // =====================================================================
    // all nodes start enabled; commands act once per new handshake word
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            node_on      <= '0;
            node_on_init <= 1'b0;
        end
        else if (!node_on_init)
        begin
            node_on      <= '1;
            node_on_init <= 1'b1;
        end
        else if (run_cmd)
        begin
            case (host_code)
                gcsw_pkg::op_disable_node:
                    node_on[host_arg] <= 1'b0;
                gcsw_pkg::op_enable_node:
                    node_on[host_arg] <= 1'b1;
                gcsw_pkg::op_enable_first:
                    for (int i = 0; i < node_count_w; i++)
                        node_on[i] <= (i < int'(host_arg));
                default:
                    node_on <= node_on;               // unknown codes ignored
            endcase
        end
    end
    // =====================================================================
    // data valid, master modes only, latched once every transaction has run
    // =====================================================================
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            sub_valid <= 1'b0;
        else if (!fieldbus_online)
            sub_valid <= 1'b0;
        else if (all_trans_ok && is_master)
            sub_valid <= 1'b1;
    end
    // =====================================================================
    // exchange gate, parameter channel and outputs
    // =====================================================================
    wire lock_on   = (feature == gcsw_pkg::gcsw_feat_on);
    // without startup lock the valid bit is ignored entirely
    assign exchange_enable = fieldbus_online && (!lock_on || host_valid);
    assign node_enabled    = node_on[cfg_node_index];
    // one word unless a configuration message says otherwise
    assign param_chan_words = param_chan_set ? param_chan_cfg
                                             : gcsw_pkg::param_chan_words_default;
    assign status_word = {gw_send, gw_ack, sub_valid, stat_code, stat_data};
    // status word read, msb first; other bytes of the area read zero here
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            in_rdata <= 8'h00;
        else if (in_addr == gcsw_pkg::stat_word_addr)
            in_rdata <= status_word[15:8];
        else if (in_addr == gcsw_pkg::stat_word_addr_lo)
            in_rdata <= status_word[7:0];
        else
            in_rdata <= 8'h00;
    end
    // mailbox framing constants are kept in the package for the loader:
    // header gcsw_pkg::mbox_header_words, data up to mbox_data_max
    // user messages carry gcsw_pkg::mbox_msg_info
endmodule

// *** logic/gcsw_pkg.sv ***
/*
 * constants for the gateway control and status word block:
 * offsets, field positions, status codes, command codes, modes.
 * assumes nothing of its surroundings; every user writes gcsw_pkg::name.
 */
package gcsw_pkg;
    // =====================================================================
    // word placement in the cyclic areas
    // =====================================================================
    localparam logic [9:0]  cmd_word_addr       = 10'h200; // output area, msb byte
    localparam logic [9:0]  cmd_word_addr_lo    = 10'h201; // output area, lsb byte
    localparam logic [9:0]  stat_word_addr      = 10'h000; // input area, msb byte
    localparam logic [9:0]  stat_word_addr_lo   = 10'h001; // input area, lsb byte
    localparam logic [15:0] cmd_word_reset      = 16'h0000;
    // =====================================================================
    // field positions of the command word
    // =====================================================================
    localparam int cmd_ack_bit     = 15;
    localparam int cmd_send_bit    = 14;
    localparam int cmd_valid_bit   = 13;
    localparam int cmd_exec_bit    = 12;
    localparam int cmd_code_hi     = 11;
    localparam int cmd_code_lo     = 8;
    // =====================================================================
    // field positions of the status word
    // =====================================================================
    localparam int stat_send_bit   = 15;
    localparam int stat_ack_bit    = 14;
    localparam int stat_valid_bit  = 13;
    localparam int stat_code_hi    = 12;
    localparam int stat_code_lo    = 8;
    // =====================================================================
    // status codes; 0x00-0x03 generic data mode only, 0x04 and 0x1f in every mode
    // =====================================================================
    localparam logic [4:0] code_invalid_cnt = 5'h00;
    localparam logic [4:0] code_frame_err   = 5'h01;
    localparam logic [4:0] code_offline_cnt = 5'h02;
    localparam logic [4:0] code_overrun     = 5'h03;
    localparam logic [4:0] code_other_err   = 5'h04;
    localparam logic [4:0] code_no_error    = 5'h1f;
    // =====================================================================
    // command codes, serial master modes
    // =====================================================================
    localparam logic [3:0] op_disable_node  = 4'h0;
    localparam logic [3:0] op_enable_node   = 4'h1;
    localparam logic [3:0] op_enable_first  = 4'h2;
    // =====================================================================
    // mailbox framing and channel defaults
    // =====================================================================
    localparam int          mbox_header_words = 16;
    localparam int          mbox_data_max     = 128;
    localparam logic [15:0] mbox_msg_info     = 16'h4002;
    localparam logic [7:0]  param_chan_words_default = 8'h01;
    localparam int          node_count        = 256;  // one flag per node address
    // =====================================================================
    // operating modes and feature setting
    // =====================================================================
    typedef enum logic [1:0] {
        gcsw_mode_master  = 2'h0,
        gcsw_mode_master2 = 2'h1,
        gcsw_mode_generic = 2'h2
    } gcsw_mode_type;
    typedef enum logic [1:0] {
        gcsw_feat_off     = 2'h0,
        gcsw_feat_on      = 2'h1,
        gcsw_feat_nolock  = 2'h2
    } gcsw_feat_type;
endpackage

// *** logic/gcsw_event_count.sv ***
/*
 * one counter of growing event totals with a pending flag.
 * assumes the event pulse is on sys_clk; pending is cleared by the owner.
 */
`timescale 1ns/1ps
module gcsw_event_count (
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    input  wire logic       event_pulse,  // one cycle per event
    input  wire logic       take,         // report of the pending value sent
    output logic            pending,      // total grew since the last report
    output logic [7:0]      count         // running total, wraps
);
    // =====================================================================
    // counter and pending flag
    // =====================================================================
    // a new event in the cycle of take keeps pending set
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            count   <= 8'h00;
            pending <= 1'b0;
        end
        else
        begin
            if (event_pulse)
                count <= count + 8'h01;
            pending <= event_pulse | (pending & ~take);
        end
    end
endmodule

// *** bench/gcsw_monitor.sv ***
/* checker of the control and status word block, on its ports only.
   assumes one sys_clk domain and resetn async active low. */
`timescale 1ns/1ps
module gcsw_monitor (
    input wire logic                    sys_clk,
    input wire logic                    resetn,
    input wire logic                    out_wr,
    input wire logic [9:0]              out_addr,
    input wire logic [7:0]              out_wdata,
    input wire logic [9:0]              in_addr,
    input wire logic [7:0]              in_rdata,
    input wire gcsw_pkg::gcsw_feat_type feature,
    input wire logic                    fieldbus_online,
    input wire logic                    param_chan_set,
    input wire logic [7:0]              param_chan_cfg,
    input wire logic                    exchange_enable,
    input wire logic [7:0]              param_chan_words,
    input wire logic [15:0]             status_word
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // ====================================================================
    // helper logic
    // ====================================================================
    logic [7:0] cmd_hi;  // shadow of the command msb, host bits live here
    logic [7:0] rd_exp;  // byte the read port should hand out next
    assign rd_exp = (in_addr == gcsw_pkg::stat_word_addr) ? status_word[15:8] :
                    (in_addr == gcsw_pkg::stat_word_addr_lo) ? status_word[7:0] : 8'h00;
    // shadow follows writes to the msb only
    always_ff @(posedge sys_clk or negedge resetn)
        if (!resetn)
            cmd_hi <= 8'h00;
        else if (out_wr && out_addr == gcsw_pkg::cmd_word_addr)
            cmd_hi <= out_wdata;
    // ====================================================================
    // handshake steps
    // ====================================================================
    sequence host_sent;
        cmd_hi[6] != status_word[14];
    endsequence
    sequence gw_copied;
        status_word[14] == $past(cmd_hi[6]);
    endsequence
    chk_ack_copy: assert property (host_sent |=> gw_copied)
        else $error("gateway ack did not copy host send");
    chk_report_wait: assert property ((cmd_hi[7] != status_word[15]) |=>
        $stable({status_word[15], status_word[12:0]}))
        else $error("report moved before host ack");
    chk_lsb_quiet: assert property ((out_wr && out_addr == gcsw_pkg::cmd_word_addr_lo
        && cmd_hi[6] == status_word[14]) |=> $stable(status_word[14]))
        else $error("lsb write moved gateway ack");
    chk_exch_lock: assert property ((feature == gcsw_pkg::gcsw_feat_on)
        |-> exchange_enable == (fieldbus_online && cmd_hi[5]))
        else $error("locked exchange gate wrong");
    chk_exch_free: assert property ((feature != gcsw_pkg::gcsw_feat_on)
        |-> exchange_enable == fieldbus_online)
        else $error("valid bit not ignored");
    chk_param_words: assert property (param_chan_words ==
        (param_chan_set ? param_chan_cfg : 8'h01))
        else $error("parameter channel words wrong");
    chk_code_legal: assert property ($changed(status_word[15]) |->
        status_word[12:8] inside {5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h1f})
        else $error("report with unknown code");
    chk_read_byte: assert property ($past(resetn) |-> in_rdata == $past(rd_exp))
        else $error("input area byte wrong");
endmodule
bind gcsw_core gcsw_monitor gcsw_monitor_inst (.sys_clk, .resetn, .out_wr, .out_addr,
    .out_wdata, .in_addr, .in_rdata, .feature, .fieldbus_online, .param_chan_set,
    .param_chan_cfg, .exchange_enable, .param_chan_words, .status_word);

// *** bench/gcsw_host_model.sv ***
/* model of the fieldbus control system writing the command word.
   assumes the tb calls its tasks at a rising edge of sys_clk. */
`timescale 1ns/1ps
module gcsw_host_model (
    input  wire logic        sys_clk,
    input  wire logic [15:0] status_word,
    output logic             out_wr,
    output logic [9:0]       out_addr,
    output logic [7:0]       out_wdata
);
    logic [15:0] word;  // host copy of the command word
    initial
    begin
        out_wr = 1'b0;
        out_addr = 10'h000;
        out_wdata = 8'h00;
        word = 16'h0000;
    end
    // one byte write; released lines show the inverse, not the old value
    task put_byte(input logic [9:0] a, input logic [7:0] d);
        out_wr <= 1'b1;
        out_addr <= a;
        out_wdata <= d;
        @(posedge sys_clk);
        out_wr <= 1'b0;
        out_addr <= ~a;
        out_wdata <= ~d;
        @(posedge sys_clk);
    endtask
    // lsb first, msb last since it carries the send toggle
    task put_word(input logic [15:0] w);
        word = w;
        put_byte(gcsw_pkg::cmd_word_addr_lo, w[7:0]);
        put_byte(gcsw_pkg::cmd_word_addr, w[15:8]);
    endtask
    // copy the gateway send toggle, after a chosen stall
    task ack(input logic [1:0] dly);
        repeat (dly) @(posedge sys_clk);
        @(negedge sys_clk);
        word[15] = status_word[15];
        @(posedge sys_clk);
        put_byte(gcsw_pkg::cmd_word_addr, word[15:8]);
    endtask
endmodule

// *** bench/tb.sv ***
/* self-checking bench of gcsw_core with a host model on the byte port.
   assumes sys_clk at 10 MHz; events are one-cycle pulses. */
`timescale 1ns/1ps
module tb;
    logic        sys_clk, resetn, online, pset, ok_lvl, out_wr, node_en, exch;
    logic [9:0]  out_addr, in_addr;
    logic [7:0]  out_wdata, in_rdata, pcfg, nidx, pwords, n;
    logic [4:0]  ev;     // invalid, frame, offline, overrun, other
    logic [15:0] sw;     // status word
    logic [31:0] seed;   // xorshift state
    gcsw_pkg::gcsw_feat_type feat;
    gcsw_pkg::gcsw_mode_type mode;
    int          n_mismatch, num_checks, i, k;
    gcsw_core gcsw_core_inst (.sys_clk, .resetn, .out_wr, .out_addr, .out_wdata, .in_addr,
        .in_rdata, .feature(feat), .mode, .fieldbus_online(online), .param_chan_set(pset),
        .param_chan_cfg(pcfg), .ev_invalid_trans(ev[0]), .ev_frame_timeout(ev[1]),
        .ev_offline_timeout(ev[2]), .ev_overrun(ev[3]), .ev_other_err(ev[4]),
        .all_trans_ok(ok_lvl), .cfg_node_index(nidx), .exchange_enable(exch),
        .node_enabled(node_en), .param_chan_words(pwords), .status_word(sw));
    gcsw_host_model gcsw_host_model_inst (.sys_clk, .status_word(sw), .out_wr, .out_addr,
        .out_wdata);
    // ====================================================================
    // helpers
    // ====================================================================
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    // error kinds are followed by a no-error report
    function automatic logic is_err(input int c);
        return c == 0 || c == 2 || c == 4;
    endfunction
    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // send one command word, wait for the gateway ack toggle
    task cmd(input logic v, input logic e, input logic [3:0] c, input logic [7:0] a);
        @(posedge sys_clk);
        gcsw_host_model_inst.put_word({gcsw_host_model_inst.word[15],
            ~gcsw_host_model_inst.word[14], v, e, c, a});
        for (i = 0; i < 20 && sw[14] !== gcsw_host_model_inst.word[14]; i++)
            @(negedge sys_clk);
        @(negedge sys_clk);
        chk("ack toggle", 16'(gcsw_host_model_inst.word[14]), 16'(sw[14]));
    endtask
    // wait for a report, compare it, then ack after a random stall
    task report(input logic [4:0] c, input logic [7:0] d, input logic dchk);
        for (i = 0; i < 40 && sw[15] === gcsw_host_model_inst.word[15]; i++)
            @(negedge sys_clk);
        chk("status code", 16'(c), 16'(sw[12:8]));
        if (dchk)
            chk("status data", 16'(d), 16'(sw[7:0]));
        seed = xs(seed);
        gcsw_host_model_inst.ack(seed[1:0]);
    endtask
    initial
    begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    // watchdog, far beyond the few hundred cycles the tests need
    initial
    begin
        #3000000;
        n_mismatch++;
        test_done();
    end
    // ====================================================================
    // tests
    // ====================================================================
    initial
    begin
        {resetn, pset, ok_lvl, ev, in_addr, nidx, pcfg} = '0;
        online = 1'b1;
        feat = gcsw_pkg::gcsw_feat_on;
        mode = gcsw_pkg::gcsw_mode_master;
        seed = 32'h961d;
        repeat (16) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (2) @(negedge sys_clk);
        chk("status reset", 16'h1f00, sw);
        chk("param default", 16'h0001, 16'(pwords));
        seed = xs(seed);
        pset <= 1'b1;
        pcfg <= seed[7:0];
        in_addr <= 10'h000;
        @(negedge sys_clk);
        chk("param override", 16'(seed[7:0]), 16'(pwords));
        chk("status msb read", 16'h001f, 16'(in_rdata));
        chk("mailbox info", 16'h4002, gcsw_pkg::mbox_msg_info);
        $display("test reset done");
        // gate: locked, unlocked and off, valid low and high
        for (k = 0; k < 6; k++)
        begin
            feat <= gcsw_pkg::gcsw_feat_type'(k / 2);
            online <= (k != 4);
            cmd(k[0], 1'b0, 4'h0, 8'h00);
            chk("exchange", 16'(k != 4 && (k/2 != 1 || k[0])), 16'(exch));
        end
        $display("test gate done");
        seed = xs(seed);
        n = seed[7:0];
        nidx <= n;
        @(negedge sys_clk);
        chk("node after reset", 16'h0001, 16'(node_en));
        cmd(1'b1, 1'b1, gcsw_pkg::op_disable_node, n);
        chk("node disabled", 16'h0000, 16'(node_en));
        cmd(1'b1, 1'b1, gcsw_pkg::op_enable_node, n);
        chk("node enabled", 16'h0001, 16'(node_en));
        n = 8'(seed[15:8] % 254 + 1);
        cmd(1'b1, 1'b1, gcsw_pkg::op_enable_first, n);
        nidx <= n - 8'h01;
        @(negedge sys_clk);
        chk("first n last", 16'h0001, 16'(node_en));
        nidx <= n;
        @(negedge sys_clk);
        chk("first n next", 16'h0000, 16'(node_en));
        $display("test nodes done");
        mode <= gcsw_pkg::gcsw_mode_generic;
        nidx <= 8'h00;
        cmd(1'b1, 1'b1, gcsw_pkg::op_disable_node, 8'h00);
        chk("generic ignores cmd", 16'h0001, 16'(node_en));
        // one pulse of each event kind; errors end with a no-error report
        for (k = 0; k < 5; k++)
        begin
            @(posedge sys_clk);
            ev <= 5'(1 << k);
            @(posedge sys_clk);
            ev <= 5'h00;
            report(5'(k), 8'h01, k == 0 || k == 2);
            if (is_err(k))
                report(5'h1f, 8'h00, 1'b0);
        end
        $display("test reports done");
        test_done();
    end
endmodule
